// >>> design/system_clock_pkg.sv
// constants, types and decode helpers for the clock and wake controller
package system_clock_pkg;

  // ==========================================================================
  // bus geometry and register indices (byte address = index * 4)
  localparam int unsigned ADDR_W          = 10;
  localparam int unsigned IDX_W           = 8;
  localparam logic [7:0]  IDX_CLK_SRC_SEL = 8'h8F;
  localparam logic [7:0]  IDX_WAKE_MASK   = 8'h9F;
  localparam logic [7:0]  IDX_PWR_MODE    = 8'hC4;
  localparam logic [7:0]  IDX_STOP_CTRL   = 8'hC5;
  localparam logic [7:0]  IDX_STATUS      = 8'hC6;
  localparam logic [7:0]  IDX_TIMED_KEY   = 8'hC7;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ==========================================================================
  // reset values
  localparam logic [7:0] CLK_SRC_SEL_RST = 8'h9C;
  localparam logic [7:0] WAKE_MASK_RST   = 8'hFF;
  localparam logic [1:0] CLOCK_DIVIDE_RST = 2'h1;
  localparam logic       SWITCHBACK_RST  = 1'b0;

  // ==========================================================================
  // field positions
  localparam int unsigned PRESCALE_LSB   = 4;
  localparam int unsigned SETTLE_LSB     = 2;
  localparam int unsigned SRC_LSB        = 0;
  localparam int unsigned CLOCK_DIV_LSB  = 6;
  localparam int unsigned SWITCHBACK_BIT = 5;
  localparam int unsigned STOP_BIT       = 0;
  localparam int unsigned SLEEP_BIT      = 1;
  localparam int unsigned PIN_LINES      = 2;

  // ==========================================================================
  // encodings and counts
  localparam logic [1:0] SRC_INT    = 2'h0;
  localparam logic [1:0] SRC_SLOW   = 2'h1;
  localparam logic [1:0] SRC_RTC    = 2'h2;
  localparam logic [1:0] SRC_PLL    = 2'h3;
  localparam logic [1:0] CD_SLOW    = 2'h3;
  localparam logic [1:0] CD_FULL    = 2'h1;
  localparam int unsigned SLOW_DIV  = 257;
  localparam logic [8:0] SLOW_LAST  = 9'(SLOW_DIV - 1);
  localparam logic [7:0] SETTLE_BASE = 8'h10;
  localparam logic [7:0] TA_KEY1     = 8'hAA;
  localparam logic [7:0] TA_KEY2     = 8'h55;
  localparam logic [6:0] TA_WINDOW_CYC = 7'h40;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_RUN    = 2'b01,
    ST_STOP   = 2'b11,
    ST_WAKE   = 2'b10
  } pwr_state_type;

  // prescale code to divide ratio: 0 pass, 1..8 even, 9..15 powers of two
  function automatic logic [11:0] prescale_ratio(input logic [3:0] code);
    if (code == 4'h0) begin
      return 12'h001;
    end else if (code <= 4'h8) begin
      return {7'h00, code, 1'b0};
    end else begin
      return 12'h001 << (code - 4'h4);
    end
  endfunction

  function automatic logic [7:0] settle_len(input logic [1:0] sel);
    return SETTLE_BASE << sel;
  endfunction

endpackage

// >>> design/div_if.sv
// carrier between the controller and its oscillator prescaler
interface div_if;
  logic       src_tick;
  logic [3:0] code;
  logic       tick;
  modport ctrl (output src_tick, output code, input tick);
  modport div  (input src_tick, input code, output tick);
endinterface

// >>> design/edge_sync.sv
// two-flop synchroniser with rise and fall detection behind it
module edge_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sync_type;

  sync_type s_r;
  sync_type s_nxt;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = raw;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // edges only look at the second and third stages
  assign rise = s_r.s2 & ~s_r.s3;
  assign fall = ~s_r.s2 & s_r.s3;
endmodule // edge_sync

// >>> design/prescale_divider.sv
// divides internal oscillator ticks by the prescale ratio
module prescale_divider
  import system_clock_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic arst_n,
  div_if.div        port
);
  typedef struct packed {
    logic [11:0] cnt;
    logic [3:0]  code;
    logic        tick;
  } div_state_type;

  div_state_type s_r;
  div_state_type s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (port.src_tick) begin
      if (s_r.cnt >= prescale_ratio(s_r.code) - 12'h001) begin
        s_nxt.cnt  = '0;
        s_nxt.tick = 1'b1;
        // new ratio only at a period boundary, so no runt period
        s_nxt.code = port.code;
      end else begin
        s_nxt.cnt = s_r.cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '{cnt: '0, code: CLK_SRC_SEL_RST[PRESCALE_LSB +: 4], tick: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign port.tick = s_r.tick;
endmodule // prescale_divider

// >>> design/system_clock_select_and_wake_control.sv
// system clock selection, slow mode, stop/wake and regulator settle control
//
// How it works
// - slow mode gives the cpu one tick per 257 system clock ticks
// - other peripherals keep the undivided system clock in slow mode
// - divide field 11 enters slow mode, writing 01 returns full speed
// - with switchback enabled, peripheral activity ends slow mode itself
// - prescale code divides internal oscillator: 1, 2..16 even, 32..2048
// - after reset or sleep wake, wait 16/32/64/128 slow internal cycles
// - source field picks internal, slow, rtc or pll oscillator
// - reset selects the internal oscillator as source
// - clock select register resets to 9C and needs the unlock sequence
// - wake mask resets to all ones and needs the unlock sequence
// - mask bits 7..1 enable lines 8,7,6,4,3,2 and pin 1 as wakers
// - mask bit 0 enables pin 0 as waker, clear blocks it
// - an enabled wake restarts the internal oscillator and the clock
// - wake follows the edge, whatever the interrupt trigger type
// - wake ignores interrupt enables; disabled ones resume without vector
// - clocked peripherals never wake the chip from stop
// - comparator and rtc events may wake the chip from stop
// - stop without sleep gates all clocks; wake clears stop itself
// - on wake from stop without sleep, resume at the first internal oscillator edge
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
module system_clock_select_and_wake_control
  import system_clock_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // oscillators arriving as pins
  input  wire logic              internal_oscillator,
  input  wire logic              slow_oscillator,
  input  wire logic              rtc_oscillator,
  input  wire logic              pll_clock,
  input  wire logic              slow_internal_oscillator,
  // wake lines: 7..2 lines 8,7,6,4,3,2 (high active), 1..0 pins (low active)
  input  wire logic [7:0]        wake_line,
  input  wire logic [7:0]        irq_enable,
  input  wire logic              switchback_event,
  // clock ticks and power controls
  output logic                   system_clock_tick,
  output logic                   cpu_clock_tick,
  output logic                   periph_clock_tick,
  output logic                   internal_osc_enable,
  output logic                   main_regulator_enable,
  output logic                   wake_isr_req,
  output logic                   wake_resume_next
);

  // ==========================================================================
  // state
  typedef struct packed {
    // registers seen by software
    logic [7:0]       clk_src_sel;
    logic [7:0]       wake_mask;
    logic [1:0]       clock_divide;
    logic             switchback_enable;
    logic             stop;
    logic             sleep;
    logic             key_stage;
    logic [6:0]       key_window;
    // bus slave
    logic             awready;
    logic             wready;
    logic             aw_got;
    logic             w_got;
    logic [IDX_W-1:0] aw_idx;
    logic             aw_aligned;
    logic [7:0]       w_data;
    logic             w_lane0;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [7:0]       rdata;
    logic [1:0]       rresp;
    // clock and power
    pwr_state_type    state;
    logic             from_sleep;
    logic [7:0]       settle_cnt;
    logic [1:0]       active_src;
    logic             slow_active;
    logic [8:0]       slow_cnt;
    logic             sys_tick;
    logic             cpu_tick;
    logic             periph_tick;
    logic             osc_en;
    logic             reg_en;
    logic             isr_req;
    logic             resume_next;
  } ctrl_state_type;

  ctrl_state_type s_r;
  ctrl_state_type s_nxt;

  // ==========================================================================
  // decode helpers
  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    return (idx == IDX_CLK_SRC_SEL) || (idx == IDX_WAKE_MASK) ||
           (idx == IDX_PWR_MODE) || (idx == IDX_STOP_CTRL) ||
           (idx == IDX_STATUS) || (idx == IDX_TIMED_KEY);
  endfunction

  function automatic logic [7:0] read_value(input ctrl_state_type s,
                                            input logic [IDX_W-1:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      IDX_CLK_SRC_SEL: v = s.clk_src_sel;
      IDX_WAKE_MASK:   v = s.wake_mask;
      IDX_PWR_MODE:    v = {s.clock_divide, s.switchback_enable, 5'h00};
      IDX_STOP_CTRL:   v = {6'h00, s.sleep, s.stop};
      IDX_STATUS:      v = {2'h0, s.key_window != 7'h00, s.osc_en, s.reg_en,
                            s.slow_active, s.state};
      default:         v = 8'h00;
    endcase
    return v;
  endfunction

  // ==========================================================================
  // oscillator and wake line synchronisers
  logic [4:0] osc_rise;
  logic [7:0] line_rise;
  logic [7:0] line_fall;

  edge_sync #(.W(5)) osc_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .raw     ({slow_internal_oscillator, pll_clock, rtc_oscillator,
               slow_oscillator, internal_oscillator}),
    .rise    (osc_rise),
    .fall    ()
  );

  edge_sync #(.W(8)) wake_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .raw     (wake_line),
    .rise    (line_rise),
    .fall    (line_fall)
  );

  // ==========================================================================
  // internal oscillator prescaler
  div_if dv ();

  assign dv.src_tick = osc_rise[0];
  assign dv.code     = s_r.clk_src_sel[PRESCALE_LSB +: 4];

  prescale_divider prescaler (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .port    (dv)
  );

  // ==========================================================================
  // combinational glue
  logic       src_tick;
  logic [7:0] wake_edge;
  logic [7:0] wake_hit;
  logic       ta_open;

  always_comb begin
    case (s_r.active_src)
      SRC_INT:  src_tick = dv.tick;
      SRC_SLOW: src_tick = osc_rise[1];
      SRC_RTC:  src_tick = osc_rise[2];
      SRC_PLL:  src_tick = osc_rise[3];
      default:  src_tick = 1'b0;
    endcase
  end

  // pins wake on the falling edge, the other lines on the rising edge,
  // regardless of how the interrupt itself is triggered
  assign wake_edge = {line_rise[7:PIN_LINES], line_fall[PIN_LINES-1:0]};
  // only the asynchronous lines reach here; comparator and rtc share them
  assign wake_hit  = wake_edge & s_r.wake_mask;
  assign ta_open   = s_r.key_window != 7'h00;

  // ==========================================================================
  // next state
  always_comb begin
    s_nxt             = s_r;
    s_nxt.sys_tick    = 1'b0;
    s_nxt.cpu_tick    = 1'b0;
    s_nxt.periph_tick = 1'b0;
    s_nxt.isr_req     = 1'b0;
    s_nxt.resume_next = 1'b0;

    if (ta_open) begin
      s_nxt.key_window = s_r.key_window - 7'h01;
    end

    // ---- clock ticks, gated outside the run state
    // a new source may tick right after the old one; skip it, no runt
    if (s_r.state == ST_RUN && src_tick && !s_r.sys_tick) begin
      s_nxt.sys_tick    = 1'b1;
      s_nxt.periph_tick = 1'b1;
      // source changes only at a tick boundary of the running source
      s_nxt.active_src  = s_r.clk_src_sel[SRC_LSB +: 2];
      if (s_r.slow_active && s_r.slow_cnt != SLOW_LAST) begin
        s_nxt.slow_cnt = s_r.slow_cnt + 9'h001;
      end else begin
        s_nxt.slow_cnt    = '0;
        s_nxt.cpu_tick    = 1'b1;
        // divide mode follows the register only at a cpu tick boundary
        s_nxt.slow_active = (s_r.clock_divide == CD_SLOW);
      end
    end

    // ---- power state machine
    case (s_r.state)
      ST_SETTLE: begin
        if (osc_rise[4]) begin
          if (s_r.settle_cnt ==
              settle_len(s_r.clk_src_sel[SETTLE_LSB +: 2]) - 8'h01) begin
            s_nxt.settle_cnt = '0;
            s_nxt.state      = ST_RUN;
            s_nxt.from_sleep = 1'b0;
          end else begin
            s_nxt.settle_cnt = s_r.settle_cnt + 8'h01;
          end
        end
      end
      ST_RUN: begin
        if (s_r.stop) begin
          s_nxt.state      = ST_STOP;
          s_nxt.osc_en     = 1'b0;
          s_nxt.reg_en     = ~s_r.sleep;
          s_nxt.from_sleep = s_r.sleep;
        end
      end
      ST_STOP: begin
        if (wake_hit != 8'h00) begin
          s_nxt.state  = ST_WAKE;
          s_nxt.osc_en = 1'b1;
          s_nxt.reg_en = 1'b1;
          s_nxt.stop   = 1'b0;
          s_nxt.sleep  = 1'b0;
          // the wake path ignores enables; a disabled line just resumes
          if ((wake_hit & irq_enable) != 8'h00) begin
            s_nxt.isr_req = 1'b1;
          end else begin
            s_nxt.resume_next = 1'b1;
          end
        end
      end
      ST_WAKE: begin
        if (osc_rise[0]) begin
          s_nxt.state = s_r.from_sleep ? ST_SETTLE : ST_RUN;
        end
      end
      default: begin
        s_nxt.state = ST_SETTLE;
      end
    endcase

    // ---- write channel: address and data taken in either order
    if (awvalid && s_r.awready) begin
      s_nxt.aw_idx     = awaddr[ADDR_W-1:2];
      s_nxt.aw_aligned = awaddr[1:0] == 2'h0;
      s_nxt.aw_got     = 1'b1;
      s_nxt.awready    = 1'b0;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_data  = wdata[7:0];
      s_nxt.w_lane0 = wstrb[0];
      s_nxt.w_got   = 1'b1;
      s_nxt.wready  = 1'b0;
    end

    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = (is_mapped(s_r.aw_idx) && s_r.aw_aligned) ?
                     RESP_OKAY : RESP_SLVERR;
      if (is_mapped(s_r.aw_idx) && s_r.aw_aligned && s_r.w_lane0) begin
        case (s_r.aw_idx)
          IDX_TIMED_KEY: begin
            // two-byte unlock opens a short window for one protected write
            if (s_r.w_data == TA_KEY1) begin
              s_nxt.key_stage = 1'b1;
            end else begin
              s_nxt.key_stage = 1'b0;
              if (s_r.key_stage && s_r.w_data == TA_KEY2) begin
                s_nxt.key_window = TA_WINDOW_CYC;
              end
            end
          end
          IDX_CLK_SRC_SEL: begin
            if (ta_open) begin
              s_nxt.clk_src_sel = s_r.w_data;
              s_nxt.key_window  = '0;
            end
          end
          IDX_WAKE_MASK: begin
            if (ta_open) begin
              s_nxt.wake_mask  = s_r.w_data;
              s_nxt.key_window = '0;
            end
          end
          IDX_PWR_MODE: begin
            s_nxt.clock_divide      = s_r.w_data[CLOCK_DIV_LSB +: 2];
            s_nxt.switchback_enable = s_r.w_data[SWITCHBACK_BIT];
          end
          IDX_STOP_CTRL: begin
            // a set arriving with the hardware clear wins
            if (s_r.w_data[STOP_BIT]) begin
              s_nxt.stop  = 1'b1;
              s_nxt.sleep = s_r.w_data[SLEEP_BIT];
            end else begin
              s_nxt.stop  = 1'b0;
              s_nxt.sleep = 1'b0;
            end
          end
          default: begin
            s_nxt.key_stage = s_r.key_stage;
          end
        endcase
      end
    end

    if (s_r.bvalid && bready) begin
      s_nxt.bvalid  = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready  = 1'b1;
    end

    // ---- read channel
    if (arvalid && s_r.arready) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid  = 1'b1;
      s_nxt.rdata   = read_value(s_r, araddr[ADDR_W-1:2]);
      s_nxt.rresp   = (is_mapped(araddr[ADDR_W-1:2]) && araddr[1:0] == 2'h0) ?
                      RESP_OKAY : RESP_SLVERR;
    end
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid  = 1'b0;
      s_nxt.arready = 1'b1;
    end

    // ---- switchback last, so hardware beats a same-cycle software write
    if (s_r.clock_divide == CD_SLOW && s_r.switchback_enable &&
        switchback_event) begin
      s_nxt.clock_divide = CD_FULL;
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r                   <= '0;
      s_r.clk_src_sel       <= CLK_SRC_SEL_RST;
      s_r.wake_mask         <= WAKE_MASK_RST;
      s_r.clock_divide      <= CLOCK_DIVIDE_RST;
      s_r.switchback_enable <= SWITCHBACK_RST;
      s_r.awready           <= 1'b1;
      s_r.wready            <= 1'b1;
      s_r.arready           <= 1'b1;
      s_r.state             <= ST_SETTLE;
      s_r.active_src        <= SRC_INT;
      s_r.osc_en            <= 1'b1;
      s_r.reg_en            <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // outputs
  assign awready               = s_r.awready;
  assign wready                = s_r.wready;
  assign bvalid                = s_r.bvalid;
  assign bresp                 = s_r.bresp;
  assign arready               = s_r.arready;
  assign rvalid                = s_r.rvalid;
  assign rdata                 = {24'h000000, s_r.rdata};
  assign rresp                 = s_r.rresp;
  assign system_clock_tick     = s_r.sys_tick;
  assign cpu_clock_tick        = s_r.cpu_tick;
  assign periph_clock_tick     = s_r.periph_tick;
  assign internal_osc_enable   = s_r.osc_en;
  assign main_regulator_enable = s_r.reg_en;
  assign wake_isr_req          = s_r.isr_req;
  assign wake_resume_next      = s_r.resume_next;

endmodule // system_clock_select_and_wake_control

// >>> test/system_clock_select_and_wake_control_properties.sv
// port-level checks for the clock selection and wake controller
module system_clock_select_and_wake_control_properties (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic [31:0] rdata,
  input wire logic        system_clock_tick,
  input wire logic        cpu_clock_tick,
  input wire logic        periph_clock_tick,
  input wire logic        internal_osc_enable,
  input wire logic        wake_isr_req,
  input wire logic        wake_resume_next
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ========
  // assertions
  chk_periph_full: assert property (periph_clock_tick == system_clock_tick)
    else $error("peripheral tick differs from system tick");
  chk_cpu_in_sys: assert property (cpu_clock_tick |-> system_clock_tick)
    else $error("cpu tick without system tick");
  chk_tick_no_runt: assert property (system_clock_tick |=> !system_clock_tick)
    else $error("system tick longer than one cycle");
  chk_stop_quiet: assert property (
    !internal_osc_enable && !$past(internal_osc_enable) |-> !system_clock_tick)
    else $error("tick while stopped");
  chk_wake_osc_on: assert property (
    wake_isr_req || wake_resume_next
    |-> internal_osc_enable && !$past(internal_osc_enable))
    else $error("wake pulse without oscillator restart");
  chk_wake_one_kind: assert property (!(wake_isr_req && wake_resume_next))
    else $error("both wake outcomes at once");
  chk_write_resp: assert property (
    awvalid && awready && wvalid && wready |=> !awready ##1 bvalid)
    else $error("write response timing wrong");
  chk_read_upper: assert property (
    arvalid && arready |=> rvalid && rdata[31:8] == 24'h0)
    else $error("read data late or upper bits set");
endmodule // system_clock_select_and_wake_control_properties

bind system_clock_select_and_wake_control
  system_clock_select_and_wake_control_properties i_props (.*);

// >>> test/system_clock_select_and_wake_control_test.sv
// self-checking bench for the clock selection and wake controller
module system_clock_select_and_wake_control_test
  import system_clock_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              ref_clk, arst_n, switchback_event;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic              internal_oscillator, slow_oscillator, rtc_oscillator;
  logic              pll_clock, slow_internal_oscillator;
  logic [7:0]        wake_line, irq_enable;
  logic              system_clock_tick, cpu_clock_tick, periph_clock_tick;
  logic              internal_osc_enable, main_regulator_enable;
  logic              wake_isr_req, wake_resume_next;
  int                mismatches, checked;

  system_clock_select_and_wake_control i_system_clock_select_and_wake_control (.*);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // off-grid phases keep tick spacing exact; internal one dies when disabled
  initial begin
    {internal_oscillator, slow_oscillator, rtc_oscillator} = 3'h0;
    {pll_clock, slow_internal_oscillator} = 2'h0;
    #3;
    fork
      forever #40 internal_oscillator = internal_osc_enable & ~internal_oscillator;
      forever #50 slow_oscillator = ~slow_oscillator;
      forever #70 rtc_oscillator = ~rtc_oscillator;
      forever #30 pll_clock = ~pll_clock;
      forever #30 slow_internal_oscillator = ~slow_internal_oscillator;
    join
  end
  // ========
  // shared tasks
  task automatic complete_run();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d);
    logic sa, sw, sb;
    sb = 1'b0;
    @(posedge ref_clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!sb) begin
      @(negedge ref_clk);
      sa = awready;
      sw = wready;
      sb = bvalid;
      @(posedge ref_clk);
      if (sa) awvalid <= 1'b0;
      if (sw) wvalid <= 1'b0;
      if (sb) bready <= 1'b0;
    end
  endtask

  // each protected write needs a fresh key pair
  task automatic wr_prot(input logic [7:0] idx, input logic [7:0] d);
    axi_wr(IDX_TIMED_KEY, TA_KEY1);
    axi_wr(IDX_TIMED_KEY, TA_KEY2);
    axi_wr(idx, d);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp,
                        input logic [1:0] er);
    logic        sa, sr;
    logic [31:0] d;
    logic [1:0]  r;
    sr = 1'b0;
    @(posedge ref_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!sr) begin
      @(negedge ref_clk);
      sa = arready;
      sr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge ref_clk);
      if (sa) arvalid <= 1'b0;
      if (sr) rready <= 1'b0;
    end
    check(d, {24'h0, exp});
    check(32'(r), 32'(er));
  endtask

  // cycles between two successive ticks of the chosen output
  task automatic measure(input logic cpu, output int n);
    logic t, seen;
    seen = 1'b0;
    n = 0;
    for (int k = 0; k < 6000; k++) begin
      @(negedge ref_clk);
      t = cpu ? cpu_clock_tick : system_clock_tick;
      if (seen) n++;
      if (t === 1'b1 && n > 0) break;
      if (t === 1'b1) seen = 1'b1;
    end
    @(posedge ref_clk);
  endtask

  task automatic wake_watch(input logic [7:0] lines, output logic isr,
                            output logic res);
    isr = 1'b0;
    res = 1'b0;
    wake_line <= lines;
    repeat (30) begin
      @(negedge ref_clk);
      isr = isr | wake_isr_req;
      res = res | wake_resume_next;
    end
    @(posedge ref_clk);
  endtask
  // ========
  // scenarios
  task automatic t_regs();
    rd_chk(IDX_CLK_SRC_SEL, CLK_SRC_SEL_RST, RESP_OKAY);
    rd_chk(IDX_WAKE_MASK, WAKE_MASK_RST, RESP_OKAY);
    rd_chk(IDX_PWR_MODE, 8'h40, RESP_OKAY);
    rd_chk(8'hD0, 8'h00, RESP_SLVERR);
    axi_wr(IDX_CLK_SRC_SEL, 8'h0D);
    axi_wr(IDX_WAKE_MASK, 8'h00);
    rd_chk(IDX_CLK_SRC_SEL, 8'h9C, RESP_OKAY);
    rd_chk(IDX_WAKE_MASK, 8'hFF, RESP_OKAY);
    axi_wr(IDX_PWR_MODE, 8'h5F);
    rd_chk(IDX_PWR_MODE, 8'h40, RESP_OKAY);
  endtask

  // internal oscillator is 8 cycles, slow 10, rtc 14, pll 6
  task automatic t_sources();
    logic [7:0] cfg [7] = '{8'h1C, 8'h8C, 8'h9C, 8'h0D, 8'h0E, 8'h0F, 8'h0C};
    int         per [7] = '{16, 128, 256, 10, 14, 6, 8};
    int         n;
    for (int i = 0; i < 7; i++) begin
      wr_prot(IDX_CLK_SRC_SEL, cfg[i]);
      measure(1'b0, n);
      measure(1'b0, n);
      check(32'(n), 32'(per[i]));
    end
  endtask

  task automatic t_slow();
    int n;
    axi_wr(IDX_PWR_MODE, 8'hC0);
    measure(1'b1, n);
    measure(1'b1, n);
    check(32'(n), 32'(8 * SLOW_DIV));
    measure(1'b0, n);
    check(32'(n), 32'h8);
    axi_wr(IDX_PWR_MODE, 8'h40);
    measure(1'b1, n);
    measure(1'b1, n);
    check(32'(n), 32'h8);
    axi_wr(IDX_PWR_MODE, 8'hE0);
    measure(1'b1, n);
    measure(1'b1, n);
    switchback_event <= 1'b1;
    @(posedge ref_clk);
    switchback_event <= 1'b0;
    measure(1'b1, n);
    measure(1'b1, n);
    check(32'(n), 32'h8);
    rd_chk(IDX_PWR_MODE, 8'h60, RESP_OKAY);
  endtask

  task automatic t_stop_wake();
    logic isr, res;
    wr_prot(IDX_WAKE_MASK, 8'hFE);
    axi_wr(IDX_STOP_CTRL, 8'h01);
    wake_watch(8'h02, isr, res);
    check(32'({internal_osc_enable, main_regulator_enable}),
          32'h1);
    wake_watch(8'h06, isr, res);
    check(32'({isr, res, internal_osc_enable}), 32'h3);
    rd_chk(IDX_STOP_CTRL, 8'h00, RESP_OKAY);
    // second stop with sleep: regulator drops as well
    axi_wr(IDX_STOP_CTRL, 8'h03);
    wake_watch(8'h06, isr, res);
    check(32'({internal_osc_enable, main_regulator_enable}),
          32'h0);
    wake_watch(8'h04, isr, res);
    check(32'({isr, res}), 32'h2);
  endtask
  // ========
  // main sequence and watchdog
  initial begin
    arst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, switchback_event} = 6'h0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    wake_line = 8'h03;
    irq_enable = 8'h02;
    mismatches = 0;
    checked = 0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_regs();
    t_sources();
    t_slow();
    t_stop_wake();
    complete_run();
  end

  initial begin
    #900000;
    mismatches++;
    complete_run();
  end
endmodule // system_clock_select_and_wake_control_test
